/* rtl/fpc_btn_if.sv */
// Debounced button levels and press pulses between debouncer and core.
// Assumes both ends share core_clk.
`default_nettype none
`include "fpc_defs.svh"
interface fpc_btn_if;
  logic [`FPC_NBTN-1:0] level;
  logic [`FPC_NBTN-1:0] press;
  modport deb (output level, output press);
  modport core (input level, input press);
endinterface
`default_nettype wire

/* rtl/fpc_debounce.sv */
// Debouncer bank for the front buttons.
// Assumes raw inputs already synchronous to core_clk, active high when pressed.
`default_nettype none
`include "fpc_defs.svh"
module fpc_debounce #(
  parameter logic [21:0] DEB_CYC = 22'(`FPC_DEBOUNCE_CYC)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [`FPC_NBTN-1:0] raw,
  fpc_btn_if.deb btn
);
  fpc_pkg::fpc_deb_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.press = '0;
    for (int i = 0; i < `FPC_NBTN; i++) begin
      // Any bounce restarts the stability count
      if (raw[i] == st_q.level[i]) begin
        st_d.cnt[i] = '0;
      end else if (st_q.cnt[i] == DEB_CYC - 22'h000001) begin
        st_d.cnt[i] = '0;
        st_d.level[i] = raw[i];
        st_d.press[i] = raw[i];
      end else begin
        st_d.cnt[i] = st_q.cnt[i] + 22'h000001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign btn.level = st_q.level;
  assign btn.press = st_q.press;
endmodule // fpc_debounce
`default_nettype wire

/* rtl/fpc_defs.svh */
// Constants of the front panel controller: offsets, fields, timing.
// Assumes a 100 MHz core clock.
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH
`define FPC_CLK_HZ 100000000
`define FPC_DEBOUNCE_MS 25
`define FPC_DEBOUNCE_CYC (`FPC_DEBOUNCE_MS * (`FPC_CLK_HZ / 1000))
`define FPC_NMI_PULSE_US 1000
`define FPC_NMI_CYC (`FPC_NMI_PULSE_US * (`FPC_CLK_HZ / 1000000))
`define FPC_TICK_S 1
`define FPC_TICK_CYC (`FPC_TICK_S * `FPC_CLK_HZ)
`define FPC_IDENT_DEF_S 8'h0F
`define FPC_PWR_FAULT_S 2'h2
`define FPC_NBTN 5
`define FPC_BTN_PWR 0
`define FPC_BTN_RST 1
`define FPC_BTN_SLP 2
`define FPC_BTN_NMI 3
`define FPC_BTN_ID 4
`define FPC_REG_CTRL 5'h00
`define FPC_REG_IDENT 5'h04
`define FPC_REG_FAULT 5'h08
`define FPC_REG_STATUS 5'h0C
`define FPC_REG_EVENTS 5'h10
`define FPC_CTRL_RST 16'h0000
`define FPC_CTRL_INTR_EN 0
`define FPC_CTRL_SEC_EN 1
`define FPC_CTRL_FORCE_ON 2
`define FPC_CTRL_ACT_LSB 4
`define FPC_CTRL_FORCED_LSB 8
`define FPC_CTRL_NMI_LOCK 11
`define FPC_CTRL_SEC_MASK 16'h0FFE
`define FPC_IDENT_DEF_BIT 8
`define FPC_EV_NMI 0
`define FPC_EV_VIOL 1
`define FPC_EV_INTR 2
`endif

/* rtl/fpc_front_panel.sv */
// Front panel control: NMI button, identify LED, status LED, intrusion,
// secure-mode lockout, Avalon-MM register slave.
// Assumes all inputs synchronous to core_clk; power buttons active high.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`default_nettype none
`include "fpc_defs.svh"
module fpc_front_panel #(
  parameter logic [21:0] DEB_CYC = 22'(`FPC_DEBOUNCE_CYC),
  parameter logic [16:0] NMI_CYC = 17'(`FPC_NMI_CYC),
  parameter logic [26:0] TICK_CYC = 27'(`FPC_TICK_CYC)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pb_power,
  input wire logic pb_reset,
  input wire logic pb_sleep,
  input wire logic pb_nmi,
  input wire logic pb_ident,
  input wire logic intrusion_in,
  input wire logic keyboard_lock_signal,
  input wire logic fp_lockout,
  input wire logic sys_pwr_good,
  input wire logic pwr_on_req,
  input wire logic sys_reset_n,
  input wire logic sys_ready,
  input wire logic thr_crit,
  input wire logic thr_noncrit,
  input wire logic fault_resilient_boot,
  input wire logic proc_disabled,
  input wire logic mem_mapped_out,
  output logic nmi_out,
  output logic ident_led_front,
  output logic ident_led_rear,
  output logic led_green,
  output logic led_amber,
  output logic pwr_btn_out,
  output logic rst_btn_out,
  output logic slp_btn_out,
  output logic nmi_btn_evt,
  output logic sec_viol_evt,
  output logic intrusion_evt
);
  fpc_pkg::fpc_state_s st_q, st_d;
  fpc_btn_if btn ();

  fpc_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .raw({pb_ident, pb_nmi, pb_sleep, pb_reset, pb_power}),
    .btn(btn)
  );

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a[4:2] == off[4:2];
  endfunction

  logic tick, sec_act, wr_fire, rd_go, id_cmd, crit, noncrit, degraded;
  logic [2:0] prot, viol;
  logic [7:0] id_secs;
  fpc_pkg::fpc_led_e led;

  always_comb begin
    st_d = st_q;
    st_d.evt = '0;
    tick = st_q.tick_cnt == TICK_CYC - 27'h0000001;
    rd_go = st_q.wait_r && (avs_read || avs_write);
    wr_fire = !st_q.wait_r && avs_write;
    // Secure mode only when enabled by options
    sec_act = st_q.ctrl[`FPC_CTRL_SEC_EN]
      && (keyboard_lock_signal || st_q.ctrl[`FPC_CTRL_FORCE_ON]);
    for (int i = 0; i < 3; i++) begin
      prot[i] = st_q.ctrl[`FPC_CTRL_FORCED_LSB + i]
        || (sec_act && st_q.ctrl[`FPC_CTRL_ACT_LSB + i]);
    end
    // One-second tick
    st_d.tick_cnt = tick ? '0 : st_q.tick_cnt + 27'h0000001;
    if (tick) begin
      st_d.blink = !st_q.blink;
    end
    // NMI pulse, length independent of hold time
    if (st_q.nmi) begin
      st_d.nmi_cnt = st_q.nmi_cnt - 17'h00001;
      if (st_q.nmi_cnt == 17'h00001) begin
        st_d.nmi = 1'b0;
      end
    end else if (btn.press[`FPC_BTN_NMI]) begin
      st_d.evt[`FPC_EV_NMI] = 1'b1;
      // Never protected by secure mode, only by its own lock
      if (!st_q.ctrl[`FPC_CTRL_NMI_LOCK]) begin
        st_d.nmi = 1'b1;
        st_d.nmi_cnt = NMI_CYC;
      end
    end
    // Protected buttons: gate opens on an allowed press, closes at release
    viol = '0;
    for (int i = 0; i < 3; i++) begin
      if (!btn.level[i]) begin
        st_d.gate[i] = 1'b0;
      end else if (btn.press[i]) begin
        st_d.gate[i] = !prot[i];
        viol[i] = prot[i];
      end
    end
    // Reset does nothing while system power is not good
    if (btn.press[`FPC_BTN_RST] && !sys_pwr_good) begin
      st_d.gate[`FPC_BTN_RST] = 1'b0;
    end
    if (btn.press[`FPC_BTN_PWR] && !sys_pwr_good && (sec_act || fp_lockout)) begin
      st_d.gate[`FPC_BTN_PWR] = 1'b0;
    end
    st_d.evt[`FPC_EV_VIOL] = |viol;
    st_d.btn_out = btn.level[2:0] & st_d.gate;
    // Identify button toggles, dropping any command timeout
    if (btn.press[`FPC_BTN_ID]) begin
      st_d.ident = (st_q.ident == fpc_pkg::ID_OFF) ? fpc_pkg::ID_BUTTON
        : fpc_pkg::ID_OFF;
    end else if (st_q.ident == fpc_pkg::ID_TIMED && tick) begin
      st_d.secs = st_q.secs - 8'h01;
      if (st_q.secs == 8'h01) begin
        st_d.ident = fpc_pkg::ID_OFF;
      end
    end
    id_cmd = wr_fire && hit(avs_address, `FPC_REG_IDENT);
    id_secs = avs_writedata[`FPC_IDENT_DEF_BIT] ? `FPC_IDENT_DEF_S
      : avs_writedata[7:0];
    if (id_cmd) begin
      if (id_secs == 8'h00) begin
        st_d.ident = fpc_pkg::ID_OFF;
      end else begin
        st_d.ident = fpc_pkg::ID_TIMED;
        st_d.secs = id_secs;
        st_d.tick_cnt = '0;
      end
    end
    st_d.led_front = st_d.ident != fpc_pkg::ID_OFF && st_q.blink;
    st_d.led_rear = st_d.led_front;
    // Intrusion
    st_d.intr = intrusion_in;
    st_d.evt[`FPC_EV_INTR] = (intrusion_in != st_q.intr)
      && st_q.ctrl[`FPC_CTRL_INTR_EN];
    // Power control fault: power stays on without request
    if (!pwr_on_req && sys_pwr_good) begin
      if (tick && st_q.pf_cnt != `FPC_PWR_FAULT_S) begin
        st_d.pf_cnt = st_q.pf_cnt + 2'h1;
      end
    end else begin
      st_d.pf_cnt = '0;
    end
    st_d.pwr_fault = st_d.pf_cnt == `FPC_PWR_FAULT_S;
    // NMI seen makes the system not ready until system reset
    st_d.nmi_seen = st_q.nmi || (st_q.nmi_seen && sys_reset_n);
    crit = thr_crit || st_q.pwr_fault || st_q.report[1];
    noncrit = thr_noncrit || st_q.intr || st_q.report == 2'h1;
    degraded = fault_resilient_boot || proc_disabled || mem_mapped_out;
    if (!sys_ready || st_q.nmi_seen) begin
      led = fpc_pkg::LED_OFF;
    end else if (crit) begin
      led = fpc_pkg::AMB_SOLID;
    end else if (noncrit) begin
      led = fpc_pkg::AMB_BLINK;
    end else if (degraded) begin
      led = fpc_pkg::GRN_BLINK;
    end else begin
      led = fpc_pkg::GRN_SOLID;
    end
    st_d.green = led == fpc_pkg::GRN_SOLID || (led == fpc_pkg::GRN_BLINK && st_q.blink);
    st_d.amber = led == fpc_pkg::AMB_SOLID || (led == fpc_pkg::AMB_BLINK && st_q.blink);
    // Register writes
    if (wr_fire && hit(avs_address, `FPC_REG_CTRL)) begin
      st_d.ctrl = avs_writedata[15:0];
    end
    if (wr_fire && hit(avs_address, `FPC_REG_FAULT)) begin
      st_d.report = avs_writedata[1:0];
    end
    // Set beats write-one-to-clear
    st_d.sticky = (st_q.sticky
      & ~((wr_fire && hit(avs_address, `FPC_REG_EVENTS)) ? avs_writedata[2:0] : 3'h0))
      | st_d.evt;
    // Secure state dropped on power application and system reset
    st_d.prev_pg = sys_pwr_good;
    if ((sys_pwr_good && !st_q.prev_pg) || !sys_reset_n) begin
      st_d.ctrl = st_d.ctrl & ~`FPC_CTRL_SEC_MASK;
    end
    // Bus: one wait cycle, then one ready cycle
    st_d.wait_r = !rd_go;
    if (rd_go) begin
      unique case (1'b1)
        hit(avs_address, `FPC_REG_CTRL): st_d.rdata = {16'h0000, st_q.ctrl};
        hit(avs_address, `FPC_REG_IDENT): st_d.rdata = {22'h000000, st_q.ident, st_q.secs};
        hit(avs_address, `FPC_REG_FAULT): st_d.rdata = {30'h00000000, st_q.report};
        hit(avs_address, `FPC_REG_STATUS): st_d.rdata = {22'h000000, sec_act,
          st_q.nmi_seen, degraded, noncrit, crit, st_q.pwr_fault, st_q.intr,
          st_q.amber, st_q.green, st_q.ident != fpc_pkg::ID_OFF};
        hit(avs_address, `FPC_REG_EVENTS): st_d.rdata = {29'h00000000, st_q.sticky};
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.ident <= fpc_pkg::ID_OFF;
      st_q.ctrl <= `FPC_CTRL_RST;
      st_q.wait_r <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = st_q.wait_r;
  assign nmi_out = st_q.nmi;
  assign ident_led_front = st_q.led_front;
  assign ident_led_rear = st_q.led_rear;
  assign led_green = st_q.green;
  assign led_amber = st_q.amber;
  assign pwr_btn_out = st_q.btn_out[`FPC_BTN_PWR];
  assign rst_btn_out = st_q.btn_out[`FPC_BTN_RST];
  assign slp_btn_out = st_q.btn_out[`FPC_BTN_SLP];
  assign nmi_btn_evt = st_q.evt[`FPC_EV_NMI];
  assign sec_viol_evt = st_q.evt[`FPC_EV_VIOL];
  assign intrusion_evt = st_q.evt[`FPC_EV_INTR];

  // Checks
  logic [16:0] nmi_len_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      nmi_len_q <= '0;
    end else if (ce) begin
      nmi_len_q <= nmi_out ? nmi_len_q + 17'h00001 : 17'h00000;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence nmi_press_s;
    ce && btn.press[`FPC_BTN_NMI] && !nmi_out;
  endsequence
  sequence id_write_s;
    ce && wr_fire && hit(avs_address, `FPC_REG_IDENT);
  endsequence

  nmi_pulse_len_a: assert property ($fell(nmi_out) |-> nmi_len_q == NMI_CYC)
    else $error("NMI pulse length wrong");
  nmi_event_a: assert property (nmi_press_s |=> nmi_btn_evt)
    else $error("NMI button event missing");
  nmi_secure_a: assert property (nmi_press_s ##0 !st_q.ctrl[`FPC_CTRL_NMI_LOCK]
    |=> nmi_out)
    else $error("NMI blocked without its lock");
  ident_toggle_a: assert property (ce && btn.press[`FPC_BTN_ID] && !id_cmd
    |=> (st_q.ident == fpc_pkg::ID_OFF) != $past(st_q.ident == fpc_pkg::ID_OFF))
    else $error("Identify button did not toggle");
  ident_cmd_off_a: assert property (id_write_s ##0 id_secs == 8'h00
    |=> st_q.ident == fpc_pkg::ID_OFF && !ident_led_front && !ident_led_rear)
    else $error("Identify off command ignored");
  ident_expire_a: assert property (ce && st_q.ident == fpc_pkg::ID_TIMED && tick
    && st_q.secs == 8'h01 && !btn.press[`FPC_BTN_ID] && !id_cmd
    |=> st_q.ident == fpc_pkg::ID_OFF)
    else $error("Identify timeout did not expire");
  ident_dark_a: assert property (ce && st_q.ident == fpc_pkg::ID_OFF && !id_cmd
    && !btn.press[`FPC_BTN_ID] |=> !ident_led_front && !ident_led_rear)
    else $error("Identify LED lit while off");
  viol_block_a: assert property (ce && btn.press[`FPC_BTN_PWR] && prot[0]
    |=> sec_viol_evt && !pwr_btn_out)
    else $error("Protected press not refused");
  powerup_lock_a: assert property (ce && !sys_pwr_good && (sec_act || fp_lockout)
    && btn.press[`FPC_BTN_PWR] |=> !pwr_btn_out)
    else $error("Power-up not blocked");
  secure_clear_a: assert property (ce && !sys_reset_n
    |=> (st_q.ctrl & `FPC_CTRL_SEC_MASK) == 16'h0000)
    else $error("Secure state not cleared");
  led_off_a: assert property (ce && !sys_ready |=> !led_green && !led_amber)
    else $error("Status LED lit while not ready");

  // Status LED checks only mean something on a ready system
  sequence ready_s;
    ce && sys_ready && !st_q.nmi_seen;
  endsequence

  intr_event_a: assert property (ce && st_q.ctrl[`FPC_CTRL_INTR_EN]
    && intrusion_in != st_q.intr |=> intrusion_evt)
    else $error("Intrusion change event missing");
  grn_solid_a: assert property (ready_s ##0 !crit && !noncrit && !degraded
    |=> led_green && !led_amber)
    else $error("Green not solid on a healthy system");
  amb_solid_a: assert property (ready_s ##0 crit |=> led_amber && !led_green)
    else $error("Amber not solid on a critical fault");
  pwr_fault_led_a: assert property (ready_s ##0 st_q.pwr_fault |=> led_amber)
    else $error("Power control fault not shown");
  report_crit_a: assert property (ready_s ##0 st_q.report[1]
    |=> led_amber && !led_green)
    else $error("Reported critical state not shown");
  degraded_blink_a: assert property (ready_s ##0 degraded && !crit && !noncrit
    |=> !led_amber && led_green == $past(st_q.blink))
    else $error("Degraded state not shown as green blink");
  ident_button_a: assert property (ce && btn.press[`FPC_BTN_ID] && !id_cmd
    && st_q.ident == fpc_pkg::ID_OFF |=> st_q.ident == fpc_pkg::ID_BUTTON)
    else $error("Button identify not held without timeout");
  ident_start_a: assert property (id_write_s ##0 id_secs != 8'h00
    |=> st_q.ident == fpc_pkg::ID_TIMED && st_q.secs == $past(id_secs))
    else $error("Identify command timeout not taken");
  // System reset must leave identify alone, only our own reset clears it
  ident_keep_a: assert property (ce && !sys_reset_n && !btn.press[`FPC_BTN_ID]
    && !id_cmd && !tick |=> st_q.ident == $past(st_q.ident))
    else $error("Identify state lost on system reset");
  nmi_lock_a: assert property (nmi_press_s ##0 st_q.ctrl[`FPC_CTRL_NMI_LOCK]
    |=> !nmi_out)
    else $error("Locked NMI button still fired");
  viol_cause_a: assert property (ce && (btn.press[2:0] & prot) == 3'h0
    |=> !sec_viol_evt)
    else $error("Violation event without a protected press");
  sleep_free_a: assert property (ce && btn.press[`FPC_BTN_SLP] && !prot[2]
    |=> slp_btn_out)
    else $error("Unprotected sleep press not passed on");
endmodule // fpc_front_panel
`default_nettype wire

/* rtl/fpc_pkg.sv */
// Types shared by the front panel controller modules.
// Assumes fpc_defs.svh for widths of button groups.
`default_nettype none
`include "fpc_defs.svh"
package fpc_pkg;
  typedef enum logic [1:0] {ID_OFF, ID_BUTTON, ID_TIMED} fpc_ident_e;
  typedef enum logic [2:0] {LED_OFF, GRN_SOLID, GRN_BLINK, AMB_SOLID, AMB_BLINK} fpc_led_e;
  typedef struct packed {
    logic [`FPC_NBTN-1:0] level;
    logic [`FPC_NBTN-1:0] press;
    logic [`FPC_NBTN-1:0][21:0] cnt;
  } fpc_deb_s;
  typedef struct packed {
    logic [26:0] tick_cnt;
    logic blink;
    logic [16:0] nmi_cnt;
    fpc_ident_e ident;
    logic [7:0] secs;
    logic [15:0] ctrl;
    logic [1:0] report;
    logic nmi_seen;
    logic intr;
    logic [1:0] pf_cnt;
    logic pwr_fault;
    logic [2:0] gate;
    logic [2:0] sticky;
    logic prev_pg;
    logic nmi;
    logic led_front;
    logic led_rear;
    logic green;
    logic amber;
    logic [2:0] btn_out;
    logic [2:0] evt;
    logic wait_r;
    logic [31:0] rdata;
  } fpc_state_s;
endpackage
`default_nettype wire

/* verif/fpc_front_panel_bench.sv */
// Self-checking bench of the front panel controller.
// Assumes fpc_panel_model for buttons and power; short counts via parameters.
`default_nettype none
`include "fpc_defs.svh"
module fpc_front_panel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 16;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, intrusion_in;
  logic keyboard_lock_signal, fp_lockout, sys_pwr_good, pwr_on_req, sys_reset_n;
  logic sys_ready, thr_crit, thr_noncrit, nmi_out, ident_led_front, ident_led_rear;
  logic led_green, led_amber, pwr_btn_out, rst_btn_out, slp_btn_out, stuck_on;
  logic nmi_btn_evt, sec_viol_evt, intrusion_evt;
  logic [4:0] avs_address, pb, push;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] hold;
  logic [2:0] deg;
  int mismatches = 0, n_compared = 0;
  int nmi_n = 0, nmi_run = 0, nmi_len = 0, nbe_n = 0, viol_n = 0, intr_n = 0, pwr_n = 0;

  fpc_panel_model model_u (.core_clk(core_clk), .push(push), .hold(hold),
    .pwr_on_req(pwr_on_req), .stuck_on(stuck_on), .pb(pb), .sys_pwr_good(sys_pwr_good));

  fpc_front_panel #(.DEB_CYC(22'h4), .NMI_CYC(17'h8), .TICK_CYC(27'h10)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pb_power(pb[`FPC_BTN_PWR]), .pb_reset(pb[`FPC_BTN_RST]), .pb_sleep(pb[`FPC_BTN_SLP]),
    .pb_nmi(pb[`FPC_BTN_NMI]), .pb_ident(pb[`FPC_BTN_ID]), .intrusion_in(intrusion_in),
    .keyboard_lock_signal(keyboard_lock_signal), .fp_lockout(fp_lockout),
    .sys_pwr_good(sys_pwr_good), .pwr_on_req(pwr_on_req), .sys_reset_n(sys_reset_n),
    .sys_ready(sys_ready), .thr_crit(thr_crit), .thr_noncrit(thr_noncrit),
    .fault_resilient_boot(deg[0]), .proc_disabled(deg[1]), .mem_mapped_out(deg[2]),
    .nmi_out(nmi_out), .ident_led_front(ident_led_front), .ident_led_rear(ident_led_rear),
    .led_green(led_green), .led_amber(led_amber), .pwr_btn_out(pwr_btn_out),
    .rst_btn_out(rst_btn_out), .slp_btn_out(slp_btn_out), .nmi_btn_evt(nmi_btn_evt),
    .sec_viol_evt(sec_viol_evt), .intrusion_evt(intrusion_evt));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Pulse lengths and event counts, so one-cycle outputs are never missed
  always @(posedge core_clk) begin
    if (nmi_out === 1'b1) nmi_run <= nmi_run + 1;
    else if (nmi_run != 0) begin
      nmi_len <= nmi_run;
      nmi_run <= 0;
      nmi_n <= nmi_n + 1;
    end
    if (nmi_btn_evt === 1'b1) nbe_n <= nbe_n + 1;
    if (sec_viol_evt === 1'b1) viol_n <= viol_n + 1;
    if (intrusion_evt === 1'b1) intr_n <= intr_n + 1;
    if (pwr_btn_out === 1'b1) pwr_n <= pwr_n + 1;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Request rises after an edge and is held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] v,
                     output logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= wr;
    avs_read <= ~wr;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask

  task automatic press(input logic [4:0] b, input logic [7:0] h);
    @(posedge core_clk);
    push <= b;
    hold <= h;
    @(posedge core_clk);
    push <= 5'h00;
  endtask

  // Two looks one tick apart: {green, amber, identify}
  task automatic look(output logic [2:0] a, output logic [2:0] b);
    a = {led_green, led_amber, ident_led_front};
    cyc(T);
    b = {led_green, led_amber, ident_led_front};
  endtask

  task automatic t_reset;
    logic [31:0] d;
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d, 32'h0);
    chk({led_green, led_amber, ident_led_rear}, 32'h0);
    bus(1'b0, 5'h14, 32'h0, d);
    chk(d, 32'h0);
  endtask

  task automatic t_status;
    logic [2:0] a, b;
    sys_ready <= 1'b1;
    cyc(5);
    chk({led_green, led_amber}, 32'h2);
    for (int i = 0; i < 3; i++) begin
      deg <= 3'h1 << i;
      cyc(5);
      look(a, b);
      chk({a[2] ^ b[2], a[1] | b[1]}, 32'h2);
    end
    deg <= 3'h0;
    thr_crit <= 1'b1;
    cyc(5);
    look(a, b);
    chk({a[2:1], b[2:1]}, 32'h5);
    thr_crit <= 1'b0;
    thr_noncrit <= 1'b1;
    cyc(5);
    look(a, b);
    chk({a[2] | b[2], a[1] ^ b[1]}, 32'h1);
    thr_noncrit <= 1'b0;
    wr(`FPC_REG_FAULT, 32'h1);
    cyc(5);
    look(a, b);
    chk({a[2] | b[2], a[1] ^ b[1]}, 32'h1);
    wr(`FPC_REG_FAULT, 32'h3);
    cyc(5);
    look(a, b);
    chk({a[2:1], b[2:1]}, 32'h5);
    wr(`FPC_REG_FAULT, 32'h0);
  endtask

  task automatic t_pfault;
    logic [31:0] d;
    pwr_on_req <= 1'b0;
    stuck_on <= 1'b1;
    cyc(4 * T);
    bus(1'b0, `FPC_REG_STATUS, 32'h0, d);
    chk({d[4], led_amber}, 32'h3);
    stuck_on <= 1'b0;
    pwr_on_req <= 1'b1;
    cyc(10);
  endtask

  task automatic t_nmi;
    logic [31:0] d;
    int n0, e0;
    n0 = nmi_n;
    e0 = nbe_n;
    press(5'h08, 8'h02);
    cyc(20);
    chk(nmi_n - n0, 32'h0);
    // Held far past the pulse length, which must not stretch
    press(5'h08, 8'h3C);
    cyc(80);
    chk(nmi_n - n0, 32'h1);
    chk(nmi_len, 32'h8);
    chk(nbe_n - e0, 32'h1);
    bus(1'b0, `FPC_REG_EVENTS, 32'h0, d);
    chk(d[0], 32'h1);
    wr(`FPC_REG_EVENTS, 32'h1);
    bus(1'b0, `FPC_REG_EVENTS, 32'h0, d);
    chk(d[0], 32'h0);
    chk({led_green, led_amber}, 32'h0);
  endtask

  task automatic t_ident;
    logic [31:0] d;
    logic [2:0] a, b;
    press(5'h10, 8'h0C);
    cyc(20);
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d[9:8], 32'h1);
    cyc(300);
    look(a, b);
    chk(a[0] ^ b[0], 32'h1);
    press(5'h10, 8'h0C);
    cyc(20);
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d[9:8], 32'h0);
    look(a, b);
    chk({a[0], b[0], ident_led_rear}, 32'h0);
    wr(`FPC_REG_IDENT, 32'h3);
    cyc(2 * T);
    wr(`FPC_REG_IDENT, 32'h3);
    cyc(2 * T);
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d[9:8], 32'h2);
    cyc(2 * T);
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d[9:8], 32'h0);
    wr(`FPC_REG_IDENT, 32'h1);
    cyc(T / 2);
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d[9:8], 32'h2);
    cyc(2 * T);
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d[9:8], 32'h0);
    wr(`FPC_REG_IDENT, 32'h100);
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d[9:0], 32'h20F);
    wr(`FPC_REG_IDENT, 32'h0);
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d[9:8], 32'h0);
  endtask

  task automatic t_secure;
    logic [31:0] d;
    int v0, p0, n0;
    wr(`FPC_REG_CTRL, 32'h12);
    keyboard_lock_signal <= 1'b1;
    cyc(3);
    bus(1'b0, `FPC_REG_STATUS, 32'h0, d);
    chk(d[9], 32'h1);
    keyboard_lock_signal <= 1'b0;
    cyc(3);
    bus(1'b0, `FPC_REG_STATUS, 32'h0, d);
    chk(d[9], 32'h0);
    wr(`FPC_REG_CTRL, 32'h16);
    bus(1'b0, `FPC_REG_STATUS, 32'h0, d);
    chk(d[9], 32'h1);
    wr(`FPC_REG_CTRL, 32'h12);
    keyboard_lock_signal <= 1'b1;
    v0 = viol_n;
    p0 = pwr_n;
    press(5'h01, 8'h0C);
    cyc(25);
    chk(viol_n - v0, 32'h1);
    chk(pwr_n - p0, 32'h0);
    press(5'h06, 8'h0C);
    cyc(8);
    chk({rst_btn_out, slp_btn_out}, 32'h3);
    cyc(17);
    chk(viol_n - v0, 32'h1);
    n0 = nmi_n;
    press(5'h08, 8'h0C);
    cyc(30);
    chk(nmi_n - n0, 32'h1);
    wr(`FPC_REG_CTRL, 32'h812);
    press(5'h08, 8'h0C);
    cyc(30);
    chk(nmi_n - n0, 32'h1);
    wr(`FPC_REG_IDENT, 32'hFF);
    sys_reset_n <= 1'b0;
    cyc(2);
    sys_reset_n <= 1'b1;
    bus(1'b0, `FPC_REG_CTRL, 32'h0, d);
    chk(d, 32'h0);
    bus(1'b0, `FPC_REG_IDENT, 32'h0, d);
    chk(d[9:0], 32'h2FF);
    wr(`FPC_REG_IDENT, 32'h0);
    pwr_on_req <= 1'b0;
    fp_lockout <= 1'b1;
    cyc(10);
    press(5'h01, 8'h0C);
    cyc(25);
    chk(pwr_n - p0, 32'h0);
    fp_lockout <= 1'b0;
    press(5'h01, 8'h0C);
    cyc(25);
    chk(pwr_n != p0, 32'h1);
  endtask

  task automatic t_intr;
    logic [31:0] d;
    int i0;
    wr(`FPC_REG_CTRL, 32'h1);
    i0 = intr_n;
    intrusion_in <= 1'b1;
    cyc(5);
    chk(intr_n - i0, 32'h1);
    bus(1'b0, `FPC_REG_STATUS, 32'h0, d);
    chk(d[3], 32'h1);
    intrusion_in <= 1'b0;
    cyc(5);
    chk(intr_n - i0, 32'h2);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    {rst_n, avs_read, avs_write, intrusion_in, keyboard_lock_signal, fp_lockout} = '0;
    {sys_ready, thr_crit, thr_noncrit, stuck_on, avs_address, push, hold, deg} = '0;
    avs_writedata = 32'h0;
    pwr_on_req = 1'b1;
    sys_reset_n = 1'b1;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_status();
    t_pfault();
    t_nmi();
    t_ident();
    t_secure();
    t_intr();
    tally_and_finish();
  end

  // Whole run needs about 1200 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule // fpc_front_panel_bench
`default_nettype wire

/* verif/fpc_panel_model.sv */
// Far side of the front panel: push buttons and a system power supply.
// Assumes the bench pulses push for one cycle per press, hold gives press length.
`default_nettype none
module fpc_panel_model (
  input wire logic core_clk,
  input wire logic [4:0] push,
  input wire logic [7:0] hold,
  input wire logic pwr_on_req,
  input wire logic stuck_on,
  output logic [4:0] pb,
  output logic sys_pwr_good
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0][7:0] cnt = '0;
  logic [2:0] dly = '0;
  always @(posedge core_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (push[i]) cnt[i] <= hold;
      else if (cnt[i] != 8'h00) cnt[i] <= cnt[i] - 8'h01;
    end
    dly <= {dly[1:0], pwr_on_req};
    // A stuck supply ignores the request, as a failed power switch would
    sys_pwr_good <= stuck_on | dly[2];
  end
  // Released buttons read low, as through a pull-down
  always_comb begin
    for (int i = 0; i < 5; i++) pb[i] = (cnt[i] != 8'h00);
  end
endmodule // fpc_panel_model
`default_nettype wire
